// ---- logic/lcdcd_pkg.sv ----
// constants for the lcd command decoder and display controller
package lcdcd_pkg;
  // drive mode codes held in the mode-set low bits
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_MUX2 = 2'h2;
  localparam logic [1:0] MODE_MUX3 = 2'h3;
  localparam logic [1:0] MODE_MUX4 = 2'h0;
  // opcode patterns and their masks
  localparam logic [7:0] OPC_MODE_MASK = 8'hf0;
  localparam logic [7:0] OPC_MODE_VAL = 8'hc0;
  localparam logic [7:0] OPC_PTR_MASK = 8'h80;
  localparam logic [7:0] OPC_PTR_VAL = 8'h00;
  localparam logic [7:0] OPC_SUB_MASK = 8'hf8;
  localparam logic [7:0] OPC_SUB_VAL = 8'he0;
  localparam logic [7:0] OPC_BANK_MASK = 8'hfc;
  localparam logic [7:0] OPC_BANK_VAL = 8'hf8;
  localparam logic [7:0] OPC_BLINK_MASK = 8'hf8;
  localparam logic [7:0] OPC_BLINK_VAL = 8'hf0;
  // field positions inside command and control bytes
  localparam int BIT_ENABLE = 3;
  localparam int BIT_BIAS = 2;
  localparam int BIT_IN_BANK = 1;
  localparam int BIT_OUT_BANK = 0;
  localparam int BIT_BLINK_ALT = 2;
  localparam int BIT_MORE_CTRL = 7;
  localparam int BIT_ROUTE = 6;
  // display ram geometry
  localparam int RAM_DEPTH = 80;
  localparam logic [6:0] PTR_LAST = 7'h4f;
  // apb register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_RAM_ADDR = 8'h04;
  localparam logic [7:0] REG_RAM_DATA = 8'h08;
  localparam logic [7:0] REG_HW_SUB = 8'h0c;
  // status word field positions
  localparam int ST_MODE = 0;
  localparam int ST_BIAS = 2;
  localparam int ST_ENABLE = 3;
  localparam int ST_IN_BANK = 4;
  localparam int ST_OUT_BANK = 5;
  localparam int ST_BLINK = 6;
  localparam int ST_BLINK_ALT = 8;
  localparam int ST_PTR = 16;
  localparam int ST_SUB = 24;
  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [6:0] RST_PTR = 7'h00;
  localparam logic [2:0] RST_SUB = 3'h0;
endpackage

// ---- logic/lcdcd_top.sv ----
// command decoder and display controller of a segment lcd driver
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module lcdcd_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic xfer_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  output logic ack_valid,
  output logic ack_ok,
  input wire logic [2:0] hw_subaddr,
  output logic display_enable,
  output logic bias_half,
  output logic [1:0] drive_mode,
  output logic in_bank_sel,
  output logic out_bank_sel,
  output logic blink_alt,
  output logic [1:0] blink_rate_code,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {
    PH_CTRL = 2'b00,
    PH_ONE = 2'b01,
    PH_STREAM = 2'b10
  } lcdcd_phase_t;
  // bits written per ram address for each drive mode
  function automatic logic [2:0] lcdcd_bits(input logic [1:0] m);
    unique case (m)
      lcdcd_pkg::MODE_STATIC: lcdcd_bits = 3'h1;
      lcdcd_pkg::MODE_MUX2: lcdcd_bits = 3'h2;
      lcdcd_pkg::MODE_MUX3: lcdcd_bits = 3'h3;
      lcdcd_pkg::MODE_MUX4: lcdcd_bits = 3'h4;
    endcase
  endfunction
  // true in the modes that own an alternate bank
  function automatic logic lcdcd_two_bank(input logic [1:0] m);
    lcdcd_two_bank = (m == lcdcd_pkg::MODE_STATIC) ||
                     (m == lcdcd_pkg::MODE_MUX2);
  endfunction
  // merge the top k source bits into a ram nibble at base
  function automatic logic [3:0] lcdcd_merge(input logic [3:0] old,
      input logic [7:0] src, input logic [2:0] k, input logic base);
    logic [3:0] r;
    int pos;
    r = old;
    for (int i = 0; i < 4; i++) begin
      pos = i + (base ? 2 : 0);
      if (i < int'(k) && pos < 4) begin
        r[pos] = src[7 - i];
      end
    end
    lcdcd_merge = r;
  endfunction
  logic [2:0] sub_meta, sub_sync, sub_cnt;
  lcdcd_phase_t phase;
  logic [6:0] data_ptr, ram_addr;
  logic [7:0] wr_bits;
  logic [3:0] wr_left;
  logic [3:0] ram [lcdcd_pkg::RAM_DEPTH];
  logic route_ram, in_bank, out_bank, blink_alt_raw;
  logic take, is_ctrl, is_cmd, is_data, sub_match, wr_busy, wr_now;
  logic op_mode, op_ptr, op_sub, op_bank, op_blink;
  ////////////////////////////////////////////////////////////////
  // strap pins pass two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_meta <= 3'h0;
      sub_sync <= 3'h0;
    end else begin
      sub_meta <= hw_subaddr;
      sub_sync <= sub_meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // byte classification
  assign wr_busy = (wr_left != 4'h0);
  assign rx_ready = !wr_busy;
  assign take = rx_valid && rx_ready;
  assign is_ctrl = take && (phase == PH_CTRL);
  assign is_cmd = take && (phase != PH_CTRL) && !route_ram;
  assign is_data = take && (phase != PH_CTRL) && route_ram;
  assign sub_match = (sub_cnt == sub_sync);
  // opcode match on leading bits
  assign op_mode = ((rx_byte & lcdcd_pkg::OPC_MODE_MASK) ==
                    lcdcd_pkg::OPC_MODE_VAL);
  assign op_ptr = ((rx_byte & lcdcd_pkg::OPC_PTR_MASK) ==
                   lcdcd_pkg::OPC_PTR_VAL) &&
                  (rx_byte[6:0] <= lcdcd_pkg::PTR_LAST);
  assign op_sub = ((rx_byte & lcdcd_pkg::OPC_SUB_MASK) ==
                   lcdcd_pkg::OPC_SUB_VAL);
  assign op_bank = ((rx_byte & lcdcd_pkg::OPC_BANK_MASK) ==
                    lcdcd_pkg::OPC_BANK_VAL);
  assign op_blink = ((rx_byte & lcdcd_pkg::OPC_BLINK_MASK) ==
                     lcdcd_pkg::OPC_BLINK_VAL);

  ////////////////////////////////////////////////////////////////
  // control byte sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_CTRL;
      route_ram <= 1'b0;
    end else if (xfer_start) begin
      phase <= PH_CTRL;
    end else if (is_ctrl) begin
      route_ram <= rx_byte[lcdcd_pkg::BIT_ROUTE];
      phase <= rx_byte[lcdcd_pkg::BIT_MORE_CTRL] ? PH_ONE
                                                 : PH_STREAM;
    end else if (take && phase == PH_ONE) begin
      phase <= PH_CTRL;
    end
  end

  ////////////////////////////////////////////////////////////////
  // acknowledge decision, one cycle after each byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_valid <= 1'b0;
      ack_ok <= 1'b0;
    end else begin
      ack_valid <= take;
      ack_ok <= take && (is_ctrl || sub_match);
    end
  end

  ////////////////////////////////////////////////////////////////
  // mode set fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      display_enable <= 1'b0;
      bias_half <= 1'b0;
      drive_mode <= lcdcd_pkg::RST_MODE;
    end else if (is_cmd && op_mode) begin
      display_enable <= rx_byte[lcdcd_pkg::BIT_ENABLE];
      bias_half <= rx_byte[lcdcd_pkg::BIT_BIAS];
      drive_mode <= rx_byte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // bank select, refused without an alternate bank
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_bank <= 1'b0;
      out_bank <= 1'b0;
    end else if (is_cmd && op_bank && lcdcd_two_bank(drive_mode)) begin
      in_bank <= rx_byte[lcdcd_pkg::BIT_IN_BANK];
      out_bank <= rx_byte[lcdcd_pkg::BIT_OUT_BANK];
    end
  end
  // bank choices have no effect in three or four backplanes
  assign in_bank_sel = in_bank && lcdcd_two_bank(drive_mode);
  assign out_bank_sel = out_bank && lcdcd_two_bank(drive_mode);

  ////////////////////////////////////////////////////////////////
  // blink select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_alt_raw <= 1'b0;
      blink_rate_code <= 2'h0;
    end else if (is_cmd && op_blink) begin
      blink_alt_raw <= rx_byte[lcdcd_pkg::BIT_BLINK_ALT] &&
                       lcdcd_two_bank(drive_mode);
      blink_rate_code <= rx_byte[1:0];
    end
  end
  // alternation only where a second bank exists
  assign blink_alt = blink_alt_raw && lcdcd_two_bank(drive_mode);
  ////////////////////////////////////////////////////////////////
  // data pointer and subaddress counter, auto increment on fill
  assign wr_now = wr_busy;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ptr <= lcdcd_pkg::RST_PTR;
      sub_cnt <= lcdcd_pkg::RST_SUB;
    end else if (wr_now) begin
      if (data_ptr == lcdcd_pkg::PTR_LAST) begin
        data_ptr <= 7'h00;
        sub_cnt <= sub_cnt + 3'h1;
      end else begin
        data_ptr <= data_ptr + 7'h1;
      end
    end else if (is_cmd && op_ptr) begin
      data_ptr <= rx_byte[6:0];
    end else if (is_cmd && op_sub) begin
      sub_cnt <= rx_byte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // display byte unpacking, one ram address per cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_bits <= 8'h00;
      wr_left <= 4'h0;
    end else if (is_data) begin
      wr_bits <= rx_byte;
      wr_left <= (drive_mode == lcdcd_pkg::MODE_STATIC) ? 4'h8 :
                 (drive_mode == lcdcd_pkg::MODE_MUX2) ? 4'h4 :
                 (drive_mode == lcdcd_pkg::MODE_MUX3) ? 4'h3 : 4'h2;
    end else if (wr_busy) begin
      wr_bits <= wr_bits << lcdcd_bits(drive_mode);
      wr_left <= wr_left - 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  // display ram store, gated by subaddress match
  always_ff @(posedge sys_clk) begin
    if (wr_now && sub_match) begin
      // last of three three-bit steps carries only two bits
      ram[data_ptr] <= lcdcd_merge(ram[data_ptr], wr_bits,
          (wr_left == 4'h1 && drive_mode == lcdcd_pkg::MODE_MUX3) ?
          3'h2 : lcdcd_bits(drive_mode), in_bank_sel);
    end
  end
  ////////////////////////////////////////////////////////////////
  // apb slave: answer loaded in setup, zero wait access
  assign pready = psel && penable;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_addr <= 7'h00;
    end else if (pready && pwrite && paddr == lcdcd_pkg::REG_RAM_ADDR) begin
      ram_addr <= pwdata[6:0];
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      unique case (paddr)
        lcdcd_pkg::REG_STATUS: begin
          prdata[lcdcd_pkg::ST_MODE +: 2] <= drive_mode;
          prdata[lcdcd_pkg::ST_BIAS] <= bias_half;
          prdata[lcdcd_pkg::ST_ENABLE] <= display_enable;
          prdata[lcdcd_pkg::ST_IN_BANK] <= in_bank_sel;
          prdata[lcdcd_pkg::ST_OUT_BANK] <= out_bank_sel;
          prdata[lcdcd_pkg::ST_BLINK +: 2] <= blink_rate_code;
          prdata[lcdcd_pkg::ST_BLINK_ALT] <= blink_alt;
          prdata[lcdcd_pkg::ST_PTR +: 7] <= data_ptr;
          prdata[lcdcd_pkg::ST_SUB +: 3] <= sub_cnt;
          pslverr <= pwrite;
        end
        lcdcd_pkg::REG_RAM_ADDR: prdata[6:0] <= ram_addr;
        lcdcd_pkg::REG_RAM_DATA: begin
          prdata[3:0] <= (ram_addr <= lcdcd_pkg::PTR_LAST) ?
                         ram[ram_addr] : 4'h0;
          pslverr <= pwrite;
        end
        lcdcd_pkg::REG_HW_SUB: begin
          prdata[2:0] <= sub_sync;
          pslverr <= pwrite;
        end
        default: pslverr <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence cmd_seen(logic [7:0] m, logic [7:0] v);
    is_cmd && ((rx_byte & m) == v) && !xfer_start;
  endsequence
  mode_set_a: assert property (
    cmd_seen(lcdcd_pkg::OPC_MODE_MASK, lcdcd_pkg::OPC_MODE_VAL) |=>
    display_enable == $past(rx_byte[3]) && bias_half == $past(rx_byte[2]))
    else $error("mode set fields not taken");
  drive_mode_a: assert property (
    cmd_seen(lcdcd_pkg::OPC_MODE_MASK, lcdcd_pkg::OPC_MODE_VAL) |=>
    drive_mode == $past(rx_byte[1:0]))
    else $error("drive mode not taken");
  ptr_load_a: assert property (
    is_cmd && !rx_byte[7] && rx_byte[6:0] <= 7'h4f |=>
    data_ptr == $past(rx_byte[6:0]))
    else $error("pointer load lost");
  subaddr_load_a: assert property (
    cmd_seen(lcdcd_pkg::OPC_SUB_MASK, lcdcd_pkg::OPC_SUB_VAL) |=>
    sub_cnt == $past(rx_byte[2:0]))
    else $error("subaddress load lost");
  bank_ignore_a: assert property (
    is_cmd && !lcdcd_two_bank(drive_mode) |=>
    $stable(in_bank) && $stable(out_bank))
    else $error("bank select acted in multiplex mode");
  blink_gate_a: assert property (
    !lcdcd_two_bank(drive_mode) |-> !blink_alt && !out_bank_sel)
    else $error("alternate bank used without one");
  discard_a: assert property (
    is_cmd && !(op_mode || op_ptr || op_sub || op_bank || op_blink) |=>
    $stable(drive_mode) && $stable(data_ptr) && $stable(sub_cnt) &&
    $stable(blink_rate_code) && $stable(display_enable))
    else $error("unknown opcode changed state");
  ack_match_a: assert property (
    take && !is_ctrl |=> ack_valid && ack_ok == $past(sub_match))
    else $error("acknowledge not tied to subaddress");
  blink_store_a: assert property (
    is_cmd && op_blink && !lcdcd_two_bank(drive_mode) |=> !blink_alt_raw)
    else $error("alternation stored without a second bank");
  sequence fill_start;
    is_data && drive_mode == lcdcd_pkg::MODE_MUX4;
  endsequence
  sequence fill_two;
    wr_busy [*2] ##1 !wr_busy;
  endsequence
  fill_len_a: assert property (
    fill_start |=> fill_two)
    else $error("four backplane fill not two addresses");
  route_a: assert property (
    is_ctrl && !xfer_start |=> route_ram == $past(rx_byte[6]))
    else $error("route bit not taken");
endmodule

// ---- verif/lcdcd_master_model.sv ----
// bus master model that offers control, command and display bytes
`timescale 1ns/1ps
module lcdcd_master_model (
  input wire logic sys_clk,
  input wire logic rx_ready,
  input wire logic ack_valid,
  input wire logic ack_ok,
  output logic xfer_start,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // idle link at time zero
  initial begin
    xfer_start = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h5a;
  end
  // new transfer: the next byte is a control byte
  task automatic start_xfer();
    @(posedge sys_clk);
    xfer_start <= 1'b1;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
  endtask
  // control byte with more flag and route bit
  function automatic logic [7:0] ctrl(input logic more, input logic ram);
    return {more, ram, 6'h00};
  endfunction
  // offer a byte, hold it until taken, then report the acknowledge
  task automatic send(input logic [7:0] b, output logic [1:0] ack);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    do @(posedge sys_clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_byte <= ~b; // released line never shows the old byte
    @(negedge sys_clk);
    ack = {ack_valid, ack_ok};
  endtask
endmodule

// ---- verif/lcd_driver_command_decoder_tb_top.sv ----
// self-checking bench for the lcd command decoder
`timescale 1ns/1ps
module lcd_driver_command_decoder_tb_top;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic xfer_start, rx_valid, rx_ready, ack_valid, ack_ok;
  logic [2:0] hw_subaddr;
  logic display_enable, bias_half, in_bank_sel, out_bank_sel, blink_alt;
  logic [1:0] drive_mode, blink_rate_code, ack;
  int fails, n_checks, cycles, seed;
  int m_mode, m_en, m_bias, m_inb, m_outb, m_alt, m_rate, m_ptr, m_sub;
  logic [7:0] dir [0:22] = '{8'hcd, 8'hfb, 8'hf6, 8'hce, 8'hf9, 8'hcf,
    8'hfa, 8'hf7, 8'hc4, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hd5, 8'he9,
    8'hfe, 8'h9a, 8'h4f, 8'h50, 8'h00, 8'he3, 8'hc9, 8'he2};

  lcdcd_top DUT (.sys_clk, .rst_n, .xfer_start, .rx_valid, .rx_byte,
    .rx_ready, .ack_valid, .ack_ok, .hw_subaddr, .display_enable,
    .bias_half, .drive_mode, .in_bank_sel, .out_bank_sel, .blink_alt,
    .blink_rate_code, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  lcdcd_master_model mm (.sys_clk, .rx_ready, .ack_valid, .ack_ok,
    .xfer_start, .rx_valid, .rx_byte);

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, zero or more wait cycles
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read one ram nibble back over apb and compare it
  task automatic ram_chk(input int a, input logic [3:0] e);
    apb(1'b1, lcdcd_pkg::REG_RAM_ADDR, 32'(a));
    apb(1'b0, lcdcd_pkg::REG_RAM_DATA, 32'h0);
    chk(rd[3:0], e);
  endtask
  // nibble j of a four-backplane byte, msb first into ram bit 0
  function automatic logic [3:0] nib(input logic [7:0] c, input int j);
    for (int b = 0; b < 4; b++) nib[b] = c[7 - 4 * j - b];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // behavioural model of the status settings
  function automatic int ms();
    return (m_mode == 1 || m_mode == 2);
  endfunction
  function automatic logic [31:0] exp_out();
    return {23'h0, 1'(m_en), 1'(m_bias), 2'(m_mode), 1'(m_inb & ms()),
      1'(m_outb & ms()), 1'(m_alt & ms()), 2'(m_rate)};
  endfunction
  function automatic logic [31:0] got_out();
    return {23'h0, display_enable, bias_half, drive_mode, in_bank_sel,
      out_bank_sel, blink_alt, blink_rate_code};
  endfunction
  function automatic logic [31:0] exp_st();
    return {5'h0, 3'(m_sub), 1'b0, 7'(m_ptr), 7'h0, 1'(m_alt & ms()),
      2'(m_rate), 1'(m_outb & ms()), 1'(m_inb & ms()), 1'(m_en),
      1'(m_bias), 2'(m_mode)};
  endfunction
  function automatic void apply(input logic [7:0] c);
    if (!c[7]) begin
      if (c[6:0] <= 7'h4f) m_ptr = c[6:0];
    end else if (c[7:4] == 4'hc) begin
      m_en = c[3];
      m_bias = c[2];
      m_mode = c[1:0];
    end else if (c[7:3] == 5'h1c) begin
      m_sub = c[2:0];
    end else if (c[7:2] == 6'h3e) begin
      if (ms()) begin
        m_inb = c[1];
        m_outb = c[0];
      end
    end else if (c[7:3] == 5'h1e) begin
      m_alt = c[2] & ms();
      m_rate = c[1:0];
    end
  endfunction
  // send one command and compare acknowledge and settings
  task automatic cmd(input logic [7:0] c);
    logic [1:0] a;
    int old;
    old = m_sub;
    mm.send(c, a);
    apply(c);
    if (old == m_sub) begin
      chk(a, {1'b1, 1'(m_sub == hw_subaddr)});
    end
    chk(got_out(), exp_out());
  endtask
  task automatic ctl(input logic more, input logic ram);
    mm.send(mm.ctrl(more, ram), ack);
    chk(ack, 2'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {fails, n_checks, cycles, m_mode, m_en, m_bias} = '0;
    {m_inb, m_outb, m_alt, m_rate, m_ptr, m_sub} = '0;
    seed = 97;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hw_subaddr = 3'h2;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(got_out(), exp_out());
    apb(1'b0, lcdcd_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h077f01ff, exp_st());
    apb(1'b0, lcdcd_pkg::REG_HW_SUB, 32'h0);
    chk({err, rd[2:0]}, {1'b0, hw_subaddr});
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, lcdcd_pkg::REG_STATUS, 32'hff);
    chk(err, 1'b1);
    $display("test reset and registers done");
    mm.start_xfer();
    ctl(1'b0, 1'b0);
    foreach (dir[i]) cmd(dir[i]);
    $display("test directed commands done");
    repeat (300) cmd(8'($random(seed)));
    $display("test random commands done");
    mm.start_xfer();
    ctl(1'b1, 1'b0);
    cmd(8'hcd);
    ctl(1'b1, 1'b0);
    cmd(8'hf8);
    ctl(1'b1, 1'b0);
    cmd(8'h05);
    ctl(1'b1, 1'b0);
    cmd(8'he2);
    ctl(1'b0, 1'b1);
    mm.send(8'ha5, ack);
    chk(ack, 2'h3);
    m_ptr = m_ptr + 8;
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, lcdcd_pkg::REG_RAM_ADDR, 32'(5 + i));
      apb(1'b0, lcdcd_pkg::REG_RAM_DATA, 32'h0);
      chk(rd[0], 1'((8'ha5 >> (7 - i)) & 8'h01));
    end
    apb(1'b0, lcdcd_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h077f01ff, exp_st());
    $display("test display data done");
    mm.start_xfer();
    ctl(1'b1, 1'b0);
    cmd(8'hc8);
    ctl(1'b0, 1'b1);
    mm.send(8'h3a, ack);
    chk(ack, 2'h3);
    m_ptr = m_ptr + 2;
    repeat (4) @(posedge sys_clk);
    ram_chk(13, nib(8'h3a, 0));
    ram_chk(14, nib(8'h3a, 1));
    mm.start_xfer();
    ctl(1'b1, 1'b0);
    cmd(8'h0d);
    @(posedge sys_clk);
    hw_subaddr <= 3'h5;
    repeat (3) @(posedge sys_clk);
    ctl(1'b0, 1'b1);
    mm.send(8'hff, ack);
    chk(ack, 2'h2);
    m_ptr = m_ptr + 2;
    repeat (4) @(posedge sys_clk);
    ram_chk(13, nib(8'h3a, 0));
    ram_chk(14, nib(8'h3a, 1));
    apb(1'b0, lcdcd_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h077f01ff, exp_st());
    $display("test four backplane and subaddress gating done");
    close_out();
  end
endmodule
